// [sim/tb_top.sv]
// self-checking bench for the timer channel interrupt enables
`timescale 1ns/1ns
module tb_top;
	import tci_pkg::*;
	logic                       clk_i, rst_i, cyc, stb, we, irq_o, ack, irq_seen;
	logic [7:0]                 adr;
	logic [3:0]                 sel;
	logic [31:0]                wdat, rdat;
	tci_chan_in_s [NUM_CH-1:0]  chan;
	tci_chan_req_s [NUM_CH-1:0] req;
	logic [31:0]                exp_q[$];
	int                         n_mismatch, checks_done, cyc_cnt, adc_cnt;
	int                         adc_exp;
	logic [7:0]                 e, m;

	tci_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .chan_i(chan),
		.req_o(req), .irq_o(irq_o));
	tci_far_end far_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.irq_i(irq_o), .adc_cnt_o(adc_cnt), .irq_seen_o(irq_seen));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task conclude;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] expv);
		checks_done++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, expv);
		end
	endtask

	// one classic cycle; reads leave their expectation for the monitor
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [7:0] x);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= s;
		wdat <= {24'h0, d};
		if (!w) exp_q.push_back({24'h0, x});
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// ack is registered, so pre-edge values are the answer's own cycle
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("BAD %0t unexpected read answer", $time);
			end else begin
				chk(rdat, exp_q.pop_front());
			end
		end
	end

	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 4000) begin
			n_mismatch++;
			conclude();
		end
	end

	function automatic logic [7:0] ea(int n);
		return 8'(ENABLE_BASE + CH_STRIDE * n);
	endfunction

	task ev(input int n, input logic [3:0] p);
		@(posedge clk_i);
		chan[n][3:0] <= p;
		@(posedge clk_i);
		chan[n][3:0] <= 4'h0;
		repeat (3) @(posedge clk_i);
	endtask

	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
		chan = '0;
		for (int i = 0; i < NUM_CH; i++) chan[i].count_up = 1'b1;
		rst_i = 1'b1;
		e = $urandom(32'h4551);
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int n = 0; n < NUM_CH; n++) begin
			wb(0, ea(n), 0, 4'hf, 8'h40);
			wb(1, ea(n), 8'hff, 4'hf, 0);
			wb(0, ea(n), 0, 4'hf, n == 0 ? 8'hdf : 8'hf3);
			wb(1, ea(n), 8'h00, 4'hf, 0);
			wb(0, ea(n), 0, 4'hf, 8'h40);
		end
		for (int i = 0; i < 6; i++) begin
			e = $urandom();
			m = (i % 3 == 0) ? WR_MASK_CH0 : WR_MASK_CH12;
			wb(1, ea(i % 3), e, 4'hf, 0);
			wb(0, ea(i % 3), 0, 4'hf, (e & m) | 8'h40);
		end
		adc_exp = 0;
		for (int n = 0; n < NUM_CH; n++) begin
			e = {n != 1, 7'($urandom())} | 8'h08;
			m = n == 0 ? 8'h0f : 8'h03;
			wb(1, ea(n), e, 4'hf, 0);
			ev(n, 4'hf);
			adc_exp += e[7];
			chk(adc_cnt, adc_exp);
			chk(req[n][3:0], e[3:0] & m[3:0]);
			wb(1, STATUS_BASE + 8'(4 * n), 8'h00, 4'hf, 0);
			ev(n, 4'h0);
			chk(req[n][3:0], e[3:0] & m[3:0]);
			wb(0, STATUS_BASE + 8'(4 * n), 0, 4'hf, 8'hc0 | m);
			wb(1, STATUS_BASE + 8'(4 * n), 8'hff & ~m, 4'hf, 0);
			ev(n, 4'h0);
			chk(req[n][3:0], 4'h0);
		end
		wb(1, IRQ_STATUS_ADR, 8'h07, 4'hf, 0);
		wb(1, ea(0), 8'h10, 4'hf, 0);
		wb(1, ea(1), 8'h20, 4'hf, 0);
		@(posedge clk_i);
		chan[0].count <= CNT_MAX;
		chan[1].phase_mode <= 1'b1;
		chan[1].count <= CNT_MAX;
		@(posedge clk_i);
		chan[0].count <= CNT_MIN;
		repeat (4) @(posedge clk_i);
		chk(req[0].overflow, 1'b1);
		chk(req[1].underflow, 1'b1);
		wb(0, STATUS_BASE, 0, 4'hf, 8'hd0);
		wb(1, STATUS_BASE, 8'hff, 4'hf, 0);
		repeat (2) @(posedge clk_i);
		chk(req[0].overflow, 1'b1);
		chk(irq_o, 1'b0);
		wb(0, IRQ_STATUS_ADR, 0, 4'hf, 8'h03);
		wb(1, IRQ_MASK_ADR, 8'h01, 4'hf, 0);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1'b1);
		chk(irq_seen, 1'b1);
		wb(1, IRQ_STATUS_ADR, 8'h01, 4'hf, 0);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1'b0);
		wb(1, 8'h30, 8'hff, 4'hf, 0);
		wb(0, 8'h30, 0, 4'hf, 8'h00);
		wb(1, ea(1), 8'h01, 4'he, 0);
		wb(0, ea(1), 0, 4'hf, 8'h60);
		repeat (3) @(posedge clk_i);
		conclude();
	end
endmodule // tb_top

// [sim/tci_far_end.sv]
// interrupt controller and converter trigger model at the request outputs
`timescale 1ns/1ns
module tci_far_end
	import tci_pkg::*;
(
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire tci_chan_req_s [NUM_CH-1:0] req_i,
	input  wire logic                       irq_i,
	output int                              adc_cnt_o,
	output logic                            irq_seen_o
);
	// each cycle with a trigger high is one conversion start, so count levels not edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adc_cnt_o  <= 0;
			irq_seen_o <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (req_i[i].adc_trigger === 1'b1) begin
					adc_cnt_o <= adc_cnt_o + 1;
				end
			end
			irq_seen_o <= irq_i;
		end
	end
endmodule // tci_far_end

// [src/tci_channel.sv]
// one timer channel: enable register, status flags and request gating
`timescale 1ns/1ns
module tci_channel
	import tci_pkg::*;
#(
	parameter int CH_IDX = 0
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire tci_chan_in_s  chan_i,
	input  wire logic          en_wr_i,
	input  wire logic          st_wr_i,
	input  wire logic          st_rd_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic [7:0]    seen_i,
	output logic [7:0]         enable_o,
	output logic [7:0]         status_o,
	output tci_chan_req_s      req_o
);

	localparam bit         IS_CH0    = (CH_IDX == 0);
	localparam logic [7:0] WR_MASK   = IS_CH0 ? WR_MASK_CH0 : WR_MASK_CH12;
	localparam logic [5:0] FLAG_MASK = IS_CH0 ? FLAG_MASK_CH0 : FLAG_MASK_CH12;

	logic [7:0]  enable;
	logic [5:0]  flags;
	logic [5:0]  armed;
	logic [5:0]  set_ev;
	logic [5:0]  clr;
	logic [15:0] prev_count;
	logic        prev_valid;
	logic        overflow_ev;
	logic        underflow_ev;

	// unimplemented bits are masked off; the reserved-one bit is forced on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable <= ENABLE_RESET;
		end else if (en_wr_i) begin
			enable <= (wdata_i & WR_MASK) | ENABLE_RESET;
		end
	end

	// first cycle after reset has no valid previous count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_count <= CNT_MIN;
			prev_valid <= 1'b0;
		end else begin
			prev_count <= chan_i.count;
			prev_valid <= 1'b1;
		end
	end

	assign overflow_ev  = prev_valid && prev_count == CNT_MAX
		&& chan_i.count == CNT_MIN;
	assign underflow_ev = prev_valid && chan_i.phase_mode
		&& prev_count == CNT_MIN && chan_i.count == CNT_MAX;

	always_comb begin
		set_ev = {underflow_ev, overflow_ev, chan_i.match_d, chan_i.match_c,
			chan_i.match_b, chan_i.match_a} & FLAG_MASK;
		clr    = st_wr_i ? (armed & ~wdata_i[5:0]) : 6'h00;
	end

	// set beats clear so an event in the clearing cycle survives
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags <= FLAG_RESET;
		end else begin
			flags <= (flags & ~clr) | set_ev;
		end
	end

	// arm only what software actually saw as one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed <= 6'h00;
		end else if (st_wr_i) begin
			armed <= 6'h00;
		end else if (st_rd_i) begin
			armed <= seen_i[5:0] & flags & FLAG_MASK;
		end
	end

	// level requests, one cycle behind the flag and enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_o <= '0;
		end else begin
			req_o <= {chan_i.match_a & enable[BIT_ADC_TRIG], flags & enable[5:0]};
		end
	end

	assign enable_o = enable;
	assign status_o = {IS_CH0 ? 1'b1 : chan_i.count_up, 1'b1, flags};

endmodule // tci_channel

// [src/tci_pkg.sv]
// shared constants and carrier types for the timer channel interrupt enables
package tci_pkg;

	localparam int          NUM_CH          = 3;
	localparam int          ADR_W           = 8;

	// register byte addresses, one 32-bit word each
	localparam logic [7:0]  ENABLE_BASE     = 8'h00;
	localparam logic [7:0]  STATUS_BASE     = 8'h10;
	localparam logic [7:0]  CH_STRIDE       = 8'h04;
	localparam logic [7:0]  IRQ_STATUS_ADR  = 8'h20;
	localparam logic [7:0]  IRQ_MASK_ADR    = 8'h24;

	// bit positions shared by enable and status layouts
	localparam int          BIT_ADC_TRIG    = 7;
	localparam int          BIT_RSV_ONE     = 6;
	localparam int          BIT_UNDER       = 5;
	localparam int          BIT_OVER        = 4;
	localparam int          BIT_MATCH_D     = 3;
	localparam int          BIT_MATCH_C     = 2;
	localparam int          BIT_MATCH_B     = 1;
	localparam int          BIT_MATCH_A     = 0;

	// reset values and per-channel implemented-bit masks
	localparam logic [7:0]  ENABLE_RESET    = 8'h40;
	localparam logic [7:0]  WR_MASK_CH0     = 8'h9f;
	localparam logic [7:0]  WR_MASK_CH12    = 8'hb3;
	localparam logic [5:0]  FLAG_MASK_CH0   = 6'h1f;
	localparam logic [5:0]  FLAG_MASK_CH12  = 6'h33;
	localparam logic [5:0]  FLAG_RESET      = 6'h00;
	localparam logic [15:0] CNT_MAX         = 16'hffff;
	localparam logic [15:0] CNT_MIN         = 16'h0000;

	typedef struct packed {
		logic [15:0] count;
		logic        count_up;
		logic        phase_mode;
		logic        match_d;
		logic        match_c;
		logic        match_b;
		logic        match_a;
	} tci_chan_in_s;

	typedef struct packed {
		logic        adc_trigger;
		logic        underflow;
		logic        overflow;
		logic        match_d;
		logic        match_c;
		logic        match_b;
		logic        match_a;
	} tci_chan_req_s;

endpackage

// [src/tci_top.sv]
// wishbone slave for three timer channel enable registers and irq summary
// Notes on behaviour
// - three enable registers, one per channel
// - bit 7 gates match-A conversion trigger
// - bit 6 reads one, ignores writes
// - channels 1-2 bit 5 gates underflow request
// - channel 0 bit 5 reads zero, fixed
// - bit 4 gates overflow request everywhere
// - channel 0 bit 3 gates match-D request
// - channels 1-2 bit 3 reads zero, fixed
// - channel 0 bit 2 gates match-C request
// - channels 1-2 bit 2 reads zero, fixed
// - bit 1 gates match-B request everywhere
// - bit 0 gates match-A request everywhere
// - overflow flag sets on upward wrap
// - channels 1-2 underflow flag sets on downward wrap in phase mode
// - flag clears by zero write after read
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module tci_top
	import tci_pkg::*;
(
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [ADR_W-1:0]           wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic [31:0]                     wb_dat_o,
	output logic                            wb_ack_o,
	input  wire tci_chan_in_s [NUM_CH-1:0]  chan_i,
	output tci_chan_req_s [NUM_CH-1:0]      req_o,
	output logic                            irq_o
);

	logic                   req_cyc;
	logic                   acc;
	logic                   wr_acc;
	logic                   rd_acc;
	logic [7:0]             word_adr;
	logic [7:0]             next_rdata;
	logic [NUM_CH-1:0]      en_wr;
	logic [NUM_CH-1:0]      st_wr;
	logic [NUM_CH-1:0]      st_rd;
	logic [NUM_CH-1:0][7:0] enable_rd;
	logic [NUM_CH-1:0][7:0] status_rd;
	logic [NUM_CH-1:0]      any_req;
	logic [NUM_CH-1:0]      any_req_d;
	logic [NUM_CH-1:0]      irq_status;
	logic [NUM_CH-1:0]      irq_mask;
	logic [NUM_CH-1:0]      irq_clr;

	// writes and status-read side effects land on the edge that ends the
	// cycle, so a master stalled before ack never arms or clears anything
	assign req_cyc  = wb_cyc_i & wb_stb_i;
	assign acc      = req_cyc & wb_ack_o;
	assign wr_acc   = acc & wb_we_i & wb_sel_i[0];
	assign rd_acc   = acc & ~wb_we_i;
	assign word_adr = {wb_adr_i[ADR_W-1:2], 2'b00};

	// an enable and a status register per channel, each strobe reaches only its own channel
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_ch
			localparam logic [7:0] EN_ADR = ENABLE_BASE + CH_STRIDE * 8'(c);
			localparam logic [7:0] ST_ADR = STATUS_BASE + CH_STRIDE * 8'(c);

			assign en_wr[c] = wr_acc && word_adr == EN_ADR;
			assign st_wr[c] = wr_acc && word_adr == ST_ADR;
			assign st_rd[c] = rd_acc && word_adr == ST_ADR;
			assign any_req[c] = |req_o[c][5:0];

			tci_channel #(
				.CH_IDX   (c)
			) u_ch (
				.clk_i    (clk_i),
				.rst_i    (rst_i),
				.chan_i   (chan_i[c]),
				.en_wr_i  (en_wr[c]),
				.st_wr_i  (st_wr[c]),
				.st_rd_i  (st_rd[c]),
				.wdata_i  (wb_dat_i[7:0]),
				.seen_i   (wb_dat_o[7:0]),
				.enable_o (enable_rd[c]),
				.status_o (status_rd[c]),
				.req_o    (req_o[c])
			);
		end
	endgenerate

	// unmapped addresses read as zero and swallow writes
	always_comb begin
		next_rdata = 8'h00;
		for (int i = 0; i < NUM_CH; i++) begin
			if (word_adr == ENABLE_BASE + CH_STRIDE * 8'(i)) begin
				next_rdata = enable_rd[i];
			end
			if (word_adr == STATUS_BASE + CH_STRIDE * 8'(i)) begin
				next_rdata = status_rd[i];
			end
		end
		if (word_adr == IRQ_STATUS_ADR) begin
			next_rdata = 8'(irq_status);
		end
		if (word_adr == IRQ_MASK_ADR) begin
			next_rdata = 8'(irq_mask);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req_cyc & ~wb_ack_o;
		end
	end

	// read data is frozen while ack is high and feeds the status arming
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req_cyc && !wb_ack_o) begin
			wb_dat_o <= {24'h00_0000, next_rdata};
		end
	end

	// summary: a request rising on a channel with none already up sets its sticky bit
	assign irq_clr = (wr_acc && word_adr == IRQ_STATUS_ADR)
		? wb_dat_i[NUM_CH-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			any_req_d <= '0;
		end else begin
			any_req_d <= any_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | (any_req & ~any_req_d);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask <= '0;
		end else if (wr_acc && word_adr == IRQ_MASK_ADR) begin
			irq_mask <= wb_dat_i[NUM_CH-1:0];
		end
	end

	// registered so the line cannot glitch; costs one cycle of latency
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status & irq_mask);
		end
	end

	property p_ch_isolated;
		@(posedge clk_i) disable iff (rst_i)
		en_wr[1] |=> $stable(enable_rd[0]) && $stable(enable_rd[2]);
	endproperty
	a_ch_isolated: assert property (p_ch_isolated)
		else $error("channel 1 enable write disturbed another channel");

	property p_adc_trig;
		@(posedge clk_i) disable iff (rst_i)
		chan_i[0].match_a |=>
			req_o[0].adc_trigger == $past(enable_rd[0][BIT_ADC_TRIG]);
	endproperty
	a_adc_trig: assert property (p_adc_trig)
		else $error("conversion trigger does not follow bit 7");

	property p_adc_idle;
		@(posedge clk_i) disable iff (rst_i)
		!chan_i[2].match_a |=> !req_o[2].adc_trigger;
	endproperty
	a_adc_idle: assert property (p_adc_idle)
		else $error("conversion trigger without match A");

	property p_rsv_one;
		@(posedge clk_i) disable iff (rst_i)
		en_wr[0] |=> enable_rd[0][BIT_RSV_ONE] && status_rd[0][BIT_RSV_ONE];
	endproperty
	a_rsv_one: assert property (p_rsv_one)
		else $error("reserved bit 6 did not read as one");

	property p_under_gate;
		@(posedge clk_i) disable iff (rst_i)
		##1 req_o[1].underflow ==
			$past(status_rd[1][BIT_UNDER] & enable_rd[1][BIT_UNDER]);
	endproperty
	a_under_gate: assert property (p_under_gate)
		else $error("channel 1 underflow request wrong");

	property p_ch0_bit5;
		@(posedge clk_i) disable iff (rst_i)
		en_wr[0] && wb_dat_i[BIT_UNDER] |=>
			!enable_rd[0][BIT_UNDER] && !status_rd[0][BIT_UNDER];
	endproperty
	a_ch0_bit5: assert property (p_ch0_bit5)
		else $error("channel 0 bit 5 took a write");

	property p_over_gate;
		@(posedge clk_i) disable iff (rst_i)
		##1 req_o[2].overflow ==
			$past(status_rd[2][BIT_OVER] & enable_rd[2][BIT_OVER]);
	endproperty
	a_over_gate: assert property (p_over_gate)
		else $error("channel 2 overflow request wrong");

	property p_match_d_gate;
		@(posedge clk_i) disable iff (rst_i)
		status_rd[0][BIT_MATCH_D] && enable_rd[0][BIT_MATCH_D]
			|=> req_o[0].match_d;
	endproperty
	a_match_d_gate: assert property (p_match_d_gate)
		else $error("channel 0 match D request missing");

	property p_ch1_rsv_zero;
		@(posedge clk_i) disable iff (rst_i)
		en_wr[1] |=> enable_rd[1][BIT_MATCH_D:BIT_MATCH_C] == 2'b00
			&& !req_o[1].match_d && !req_o[1].match_c;
	endproperty
	a_ch1_rsv_zero: assert property (p_ch1_rsv_zero)
		else $error("channel 1 bits 3 and 2 not zero");

	property p_ch2_rsv_zero;
		@(posedge clk_i) disable iff (rst_i)
		en_wr[2] |=> enable_rd[2][BIT_MATCH_D:BIT_MATCH_C] == 2'b00;
	endproperty
	a_ch2_rsv_zero: assert property (p_ch2_rsv_zero)
		else $error("channel 2 bits 3 and 2 not zero");

	property p_match_c_gate;
		@(posedge clk_i) disable iff (rst_i)
		!enable_rd[0][BIT_MATCH_C] |=> !req_o[0].match_c;
	endproperty
	a_match_c_gate: assert property (p_match_c_gate)
		else $error("channel 0 match C request while disabled");

	property p_match_b_gate;
		@(posedge clk_i) disable iff (rst_i)
		##1 req_o[1].match_b ==
			$past(status_rd[1][BIT_MATCH_B] & enable_rd[1][BIT_MATCH_B]);
	endproperty
	a_match_b_gate: assert property (p_match_b_gate)
		else $error("channel 1 match B request wrong");

	property p_match_a_gate;
		@(posedge clk_i) disable iff (rst_i)
		##1 req_o[0].match_a ==
			$past(status_rd[0][BIT_MATCH_A] & enable_rd[0][BIT_MATCH_A]);
	endproperty
	a_match_a_gate: assert property (p_match_a_gate)
		else $error("channel 0 match A request wrong");

	property p_overflow_set;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && $past(chan_i[0].count) == CNT_MAX
			&& chan_i[0].count == CNT_MIN |=> status_rd[0][BIT_OVER];
	endproperty
	a_overflow_set: assert property (p_overflow_set)
		else $error("overflow flag not set on upward wrap");

	property p_underflow_set;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && chan_i[1].phase_mode
			&& $past(chan_i[1].count) == CNT_MIN
			&& chan_i[1].count == CNT_MAX |=> status_rd[1][BIT_UNDER];
	endproperty
	a_underflow_set: assert property (p_underflow_set)
		else $error("underflow flag not set on downward wrap");

	property p_one_keeps;
		@(posedge clk_i) disable iff (rst_i)
		st_wr[0] && wb_dat_i[BIT_OVER] && status_rd[0][BIT_OVER]
			|=> status_rd[0][BIT_OVER];
	endproperty
	a_one_keeps: assert property (p_one_keeps)
		else $error("writing one cleared the overflow flag");

	property p_clear_cause;
		@(posedge clk_i) disable iff (rst_i)
		$fell(status_rd[0][BIT_MATCH_A]) |-> $past(st_wr[0]);
	endproperty
	a_clear_cause: assert property (p_clear_cause)
		else $error("flag fell without a status write");

	property p_irq_level;
		@(posedge clk_i) disable iff (rst_i)
		##1 irq_o == $past(|(irq_status & irq_mask));
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt line does not follow unmasked status");

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("bus acknowledge longer than one cycle");

endmodule // tci_top
